// ### rtl/io_port_pin_function_ctrl.sv
// Port 1 pin function and pull-up control, port 2 data, direction and mode registers
`timescale 1ns/1ps
`include "io_port_consts.svh"
`default_nettype none

module io_port_pin_function_ctrl (
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire io_port_pkg::reg_req_t  reg_req,
    output var  logic [7:0]             reg_rdata,
    input  wire io_port_pkg::op_mode_t  op_mode,
    input  wire logic [2:0]             timer_b_mode_field,
    input  wire io_port_pkg::alt_out_t  alt_out,
    output var  io_port_pkg::alt_in_t   alt_in,
    input  wire logic [7:0]             p1_pin_in,
    output var  io_port_pkg::pin_drive_t p1_pin_drive,
    output var  logic [7:0]             p1_pullup_on,
    input  wire logic [7:0]             p2_pin_in,
    output var  io_port_pkg::pin_drive_t p2_pin_drive
);
    import io_port_pkg::*;

    port_state_t s_r;
    port_state_t s_nxt;

    // Address decode shared by writes and reads
    function automatic reg_sel_t reg_sel(input logic [15:0] addr);
        reg_sel_t sel;
        sel = SEL_NONE;
        case (addr)
            `PORT2_PIN_MODE_ADDR:    sel = SEL_P2_MODE;
            `PORT2_DRIVE_MODE_ADDR:  sel = SEL_P2_DRIVE;
            `PORT2_DATA_ADDR:        sel = SEL_P2_DATA;
            `PORT2_DIRECTION_ADDR:   sel = SEL_P2_DIR;
            `PORT1_PIN_MODE_ADDR:    sel = SEL_P1_MODE;
            `PORT1_PULLUP_CTRL_ADDR: sel = SEL_P1_PULLUP;
            `PORT1_DATA_ADDR:        sel = SEL_P1_DATA;
            `PORT1_DIRECTION_ADDR:   sel = SEL_P1_DIR;
            default:                 sel = SEL_NONE;
        endcase
        return sel;
    endfunction

    always_comb
    begin
        logic [7:0] p1_oe_eff;
        logic [7:0] p1_out_eff;
        logic [7:0] p2_general;
        p1_oe_eff  = s_r.p1_dir;
        p1_out_eff = s_r.p1_data;
        p2_general = 8'hff;
        s_nxt = s_r;

        // Two-stage pin synchronisers
        s_nxt.p1_meta = p1_pin_in;
        s_nxt.p1_sync = s_r.p1_meta;
        s_nxt.p2_meta = p2_pin_in;
        s_nxt.p2_sync = s_r.p2_meta;

        // Register writes
        if (reg_req.wr)
        begin
            case (reg_sel(reg_req.addr))
                SEL_P2_MODE:   s_nxt.p2_mode = reg_req.wdata | `PORT2_PIN_MODE_FIXED;
                SEL_P2_DRIVE:  s_nxt.p2_drive = reg_req.wdata;
                SEL_P2_DATA:   s_nxt.p2_data = reg_req.wdata;
                SEL_P2_DIR:    s_nxt.p2_dir = reg_req.wdata;
                SEL_P1_MODE:   s_nxt.p1_mode = reg_req.wdata[4:0];
                SEL_P1_PULLUP: s_nxt.p1_puc = reg_req.wdata;
                SEL_P1_DATA:   s_nxt.p1_data = reg_req.wdata;
                SEL_P1_DIR:    s_nxt.p1_dir = reg_req.wdata;
                default:       s_nxt.p2_data = s_r.p2_data;
            endcase
        end

        // Register reads, data valid in the following cycle only
        s_nxt.rdata = `UNMAPPED_READ;
        if (reg_req.rd)
        begin
            case (reg_sel(reg_req.addr))
                SEL_P2_MODE:   s_nxt.rdata = s_r.p2_mode;
                SEL_P2_DRIVE:  s_nxt.rdata = s_r.p2_drive;
                SEL_P2_DATA:   s_nxt.rdata = (s_r.p2_dir & s_r.p2_data)
                                           | (~s_r.p2_dir & s_r.p2_sync);
                SEL_P2_DIR:    s_nxt.rdata = `PORT2_DIRECTION_READ;
                SEL_P1_MODE:   s_nxt.rdata = {3'h0, s_r.p1_mode};
                SEL_P1_PULLUP: s_nxt.rdata = s_r.p1_puc;
                SEL_P1_DATA:   s_nxt.rdata = (s_r.p1_dir & s_r.p1_data)
                                           | (~s_r.p1_dir & s_r.p1_sync);
                SEL_P1_DIR:    s_nxt.rdata = s_r.p1_dir;
                default:       s_nxt.rdata = `UNMAPPED_READ;
            endcase
        end

        // Port 1 alternate functions
        if (timer_b_mode_field == `TIMER_B_EXT_INT1)
            p1_oe_eff[5] = 1'b0;
        if (s_r.p1_mode[`P1_MODE_PWM_BIT])
        begin
            p1_oe_eff[4]  = 1'b1;
            p1_out_eff[4] = alt_out.pwm;
        end
        if (s_r.p1_mode[`P1_MODE_GATE_BIT])
            p1_oe_eff[3] = 1'b0;
        if (s_r.p1_mode[`P1_MODE_TF_HIGH_BIT])
        begin
            p1_oe_eff[2]  = 1'b1;
            p1_out_eff[2] = alt_out.tf_high;
        end
        if (s_r.p1_mode[`P1_MODE_TF_LOW_BIT])
        begin
            p1_oe_eff[1]  = 1'b1;
            p1_out_eff[1] = alt_out.tf_low;
        end
        if (s_r.p1_mode[`P1_MODE_CLK_OUT_BIT])
        begin
            p1_oe_eff[0]  = 1'b1;
            p1_out_eff[0] = alt_out.clk_out;
        end

        // Port 1 pin state by operating mode
        case (op_mode)
            OP_ACTIVE, OP_SUBACTIVE:
            begin
                s_nxt.p1_pins.oe  = p1_oe_eff;
                s_nxt.p1_pins.out = p1_out_eff;
                s_nxt.p1_pu       = ~s_r.p1_dir & s_r.p1_puc;
            end
            OP_STANDBY:
            begin
                s_nxt.p1_pins.oe = 8'h00;
                s_nxt.p1_pu      = ~s_r.p1_dir & s_r.p1_puc;
            end
            OP_SLEEP, OP_SUBSLEEP, OP_WATCH:
                s_nxt.p1_pins = s_r.p1_pins;
            default:
                s_nxt.p1_pins.oe = 8'h00;
        endcase

        // Port 2 general I/O versus alternate inputs
        p2_general[1] = ~s_r.p2_mode[`P2_MODE_COUNT_DIR_BIT];
        p2_general[0] = ~s_r.p2_mode[`P2_MODE_EXT_INT4_BIT];
        // Open-drain drives low only, push-pull drives both levels
        s_nxt.p2_pins.oe  = p2_general & s_r.p2_dir
                          & ~(s_r.p2_drive & s_r.p2_data);
        s_nxt.p2_pins.out = s_r.p2_data & ~s_r.p2_drive;

        // Alternate inputs to the peripheral units, idle high
        s_nxt.alt_in.ext_int1 = (timer_b_mode_field == `TIMER_B_EXT_INT1)
                              ? s_r.p1_sync[5] : 1'b1;
        s_nxt.alt_in.capture_gate = s_r.p1_mode[`P1_MODE_GATE_BIT]
                                  ? s_r.p1_sync[3] : 1'b1;
        s_nxt.alt_in.count_dir = s_r.p2_mode[`P2_MODE_COUNT_DIR_BIT]
                               ? s_r.p2_sync[1] : 1'b1;
        s_nxt.alt_in.ext_int4 = s_r.p2_mode[`P2_MODE_EXT_INT4_BIT]
                              ? s_r.p2_sync[0] : 1'b1;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            s_r          <= '0;
            s_r.p2_mode  <= `PORT2_PIN_MODE_RESET;
            s_r.p2_drive <= `PORT2_DRIVE_MODE_RESET;
            s_r.p2_data  <= `PORT2_DATA_RESET;
            s_r.p2_dir   <= `PORT2_DIRECTION_RESET;
            s_r.p1_mode  <= `PORT1_PIN_MODE_RESET;
            s_r.p1_puc   <= `PORT1_PULLUP_RESET;
            s_r.p1_data  <= `PORT1_DATA_RESET;
            s_r.p1_dir   <= `PORT1_DIRECTION_RESET;
            s_r.alt_in   <= 4'hf;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata    = s_r.rdata;
    assign alt_in       = s_r.alt_in;
    assign p1_pin_drive = s_r.p1_pins;
    assign p1_pullup_on = s_r.p1_pu;
    assign p2_pin_drive = s_r.p2_pins;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence s_dir_write;
        reg_req.wr && reg_req.addr == `PORT2_DIRECTION_ADDR;
    endsequence

    sequence s_dir_read;
        reg_req.rd && reg_req.addr == `PORT2_DIRECTION_ADDR;
    endsequence

    sequence s_data_read;
        reg_req.rd && reg_req.addr == `PORT2_DATA_ADDR;
    endsequence

    sequence s_reset_held;
        rst && $past(rst);
    endsequence

    dir_read_ones_a: assert property (
        s_dir_read |=> reg_rdata == `PORT2_DIRECTION_READ)
        else $error("direction register did not read as all ones");

    reset_float_a: assert property (disable iff (1'b0)
        s_reset_held |-> p1_pin_drive.oe == 8'h00 && p1_pullup_on == 8'h00)
        else $error("port 1 driven or pulled up during reset");

    reset_values_a: assert property (disable iff (1'b0)
        s_reset_held |-> s_r.p2_data == `PORT2_DATA_RESET
                         && s_r.p2_dir == `PORT2_DIRECTION_RESET
                         && s_r.p2_mode == `PORT2_PIN_MODE_RESET)
        else $error("port 2 registers not at reset values");

    input_read_a: assert property (
        s_data_read ##0 s_r.p2_dir == 8'h00 |=> reg_rdata == $past(s_r.p2_sync))
        else $error("port 2 input pins did not read live level");

    output_read_a: assert property (
        s_data_read ##0 s_r.p2_dir == 8'hff |=> reg_rdata == $past(s_r.p2_data))
        else $error("port 2 output pins did not read stored data");

    read_idle_a: assert property (
        !reg_req.rd |=> reg_rdata == `UNMAPPED_READ)
        else $error("read data stood longer than one cycle");

    mode_fixed_a: assert property (
        reg_req.rd && reg_req.addr == `PORT2_PIN_MODE_ADDR |=> reg_rdata[7:6] == 2'b11)
        else $error("fixed mode bits did not read as ones");

    p2_readback_a: assert property (
        reg_req.rd && reg_req.addr == `PORT2_DATA_ADDR
        |=> reg_rdata == (($past(s_r.p2_dir) & $past(s_r.p2_data))
                        | (~$past(s_r.p2_dir) & $past(s_r.p2_sync))))
        else $error("port 2 read returned wrong mix of data and pins");

    dir_output_a: assert property (
        s_dir_write ##1 !reg_req.wr ##1 (s_r.p2_mode[1:0] == 2'b00 && s_r.p2_drive == 8'h00)
        |=> p2_pin_drive.oe == $past(s_r.p2_dir))
        else $error("port 2 direction not applied to output enable");

    pullup_gate_a: assert property (
        op_mode == OP_ACTIVE |=> p1_pullup_on == ($past(~s_r.p1_dir) & $past(s_r.p1_puc)))
        else $error("port 1 pull-up not gated by direction and control");

    standby_float_a: assert property (
        op_mode == OP_STANDBY |=> p1_pin_drive.oe == 8'h00)
        else $error("port 1 driven in standby");

    sleep_hold_a: assert property (
        op_mode == OP_SLEEP |=> $stable(p1_pin_drive))
        else $error("port 1 changed while holding in sleep");

    ext_int1_input_select_a: assert property (
        timer_b_mode_field == 3'h7 |=> !p1_pin_drive.oe[5])
        else $error("port 1 bit 5 driven while used as interrupt input");

    pwm_out_a: assert property (
        op_mode == OP_ACTIVE && s_r.p1_mode[4]
        |=> p1_pin_drive.oe[4] && p1_pin_drive.out[4] == $past(alt_out.pwm))
        else $error("pulse-width output not on port 1 bit 4");

    clk_out_a: assert property (
        op_mode == OP_SUBACTIVE && s_r.p1_mode[0]
        |=> p1_pin_drive.oe[0] && p1_pin_drive.out[0] == $past(alt_out.clk_out))
        else $error("clock output not on port 1 bit 0");

    count_dir_a: assert property (
        s_r.p2_mode[1] |=> !p2_pin_drive.oe[1] && alt_in.count_dir == $past(s_r.p2_sync[1]))
        else $error("count direction pin not routed as input");

    open_drain_a: assert property (
        s_r.p2_drive[7] && s_r.p2_data[7] |=> !p2_pin_drive.oe[7])
        else $error("open-drain pin drove a high level");

    bit5_dir_a: assert property (
        op_mode == OP_ACTIVE && timer_b_mode_field != `TIMER_B_EXT_INT1
        |=> p1_pin_drive.oe[5] == $past(s_r.p1_dir[5]))
        else $error("port 1 bit 5 ignored its direction bit");

    int1_route_a: assert property (
        timer_b_mode_field == `TIMER_B_EXT_INT1 |=> alt_in.ext_int1 == $past(s_r.p1_sync[5]))
        else $error("interrupt 1 input not taken from port 1 bit 5");

    pwm_dir_a: assert property (
        op_mode == OP_ACTIVE && !s_r.p1_mode[`P1_MODE_PWM_BIT]
        |=> p1_pin_drive.oe[4] == $past(s_r.p1_dir[4])
            && p1_pin_drive.out[4] == $past(s_r.p1_data[4]))
        else $error("port 1 bit 4 not under direction control");

    low_dir_a: assert property (
        op_mode == OP_ACTIVE && s_r.p1_mode[3:0] == 4'h0
        |=> p1_pin_drive.oe[3:0] == $past(s_r.p1_dir[3:0]))
        else $error("port 1 bits 3 to 0 ignored their direction bits");

    gate_input_a: assert property (
        op_mode == OP_SUBACTIVE && s_r.p1_mode[`P1_MODE_GATE_BIT]
        |=> !p1_pin_drive.oe[3] && alt_in.capture_gate == $past(s_r.p1_sync[3]))
        else $error("capture gate pin not routed as input");

    tf_high_a: assert property (
        op_mode == OP_ACTIVE && s_r.p1_mode[`P1_MODE_TF_HIGH_BIT]
        |=> p1_pin_drive.oe[2] && p1_pin_drive.out[2] == $past(alt_out.tf_high))
        else $error("timer F high output not on port 1 bit 2");

    tf_low_a: assert property (
        op_mode == OP_SUBACTIVE && s_r.p1_mode[`P1_MODE_TF_LOW_BIT]
        |=> p1_pin_drive.oe[1] && p1_pin_drive.out[1] == $past(alt_out.tf_low))
        else $error("timer F low output not on port 1 bit 1");

    subsleep_hold_a: assert property (
        op_mode == OP_SUBSLEEP |=> $stable(p1_pin_drive))
        else $error("port 1 changed while holding in subsleep");

    watch_hold_a: assert property (
        op_mode == OP_WATCH |=> $stable(p1_pin_drive) && $stable(p1_pullup_on))
        else $error("port 1 changed while holding in watch");

    standby_pullup_a: assert property (
        op_mode == OP_STANDBY |=> p1_pullup_on == ($past(~s_r.p1_dir) & $past(s_r.p1_puc)))
        else $error("port 1 pull-up wrong in standby");

    ext_int4_a: assert property (
        s_r.p2_mode[`P2_MODE_EXT_INT4_BIT]
        |=> !p2_pin_drive.oe[0] && alt_in.ext_int4 == $past(s_r.p2_sync[0]))
        else $error("interrupt 4 pin not routed as input");

    push_pull_a: assert property (
        !s_r.p2_drive[6] && s_r.p2_dir[6] && s_r.p2_data[6]
        |=> p2_pin_drive.oe[6] && p2_pin_drive.out[6])
        else $error("push-pull pin did not drive a high level");

endmodule

`default_nettype wire

// ### rtl/io_port_consts.svh
// Register offsets, reset values and field positions of the I/O port block
`ifndef IO_PORT_CONSTS_SVH
`define IO_PORT_CONSTS_SVH

`define PORT2_PIN_MODE_ADDR     16'hffc9
`define PORT2_DRIVE_MODE_ADDR   16'hffcb
`define PORT2_DATA_ADDR         16'hffd5
`define PORT2_DIRECTION_ADDR    16'hffe5
`define PORT1_PIN_MODE_ADDR     16'hffc8
`define PORT1_PULLUP_CTRL_ADDR  16'hffe0
`define PORT1_DATA_ADDR         16'hffd4
`define PORT1_DIRECTION_ADDR    16'hffe4

`define PORT2_PIN_MODE_RESET    8'hc0
`define PORT2_PIN_MODE_FIXED    8'hc0
`define PORT2_DRIVE_MODE_RESET  8'h00
`define PORT2_DATA_RESET        8'h00
`define PORT2_DIRECTION_RESET   8'h00
`define PORT2_DIRECTION_READ    8'hff
`define PORT1_PIN_MODE_RESET    5'h00
`define PORT1_PULLUP_RESET      8'h00
`define PORT1_DATA_RESET        8'h00
`define PORT1_DIRECTION_RESET   8'h00
`define UNMAPPED_READ           8'h00

`define P1_MODE_PWM_BIT         4
`define P1_MODE_GATE_BIT        3
`define P1_MODE_TF_HIGH_BIT     2
`define P1_MODE_TF_LOW_BIT      1
`define P1_MODE_CLK_OUT_BIT     0
`define P2_MODE_COUNT_DIR_BIT   1
`define P2_MODE_EXT_INT4_BIT    0
`define TIMER_B_EXT_INT1        3'h7

`endif

// ### rtl/io_port_pkg.sv
// Types shared by the I/O port block
`default_nettype none
package io_port_pkg;

    typedef enum logic [2:0] {
        OP_ACTIVE    = 3'b000,
        OP_SUBACTIVE = 3'b001,
        OP_SLEEP     = 3'b010,
        OP_SUBSLEEP  = 3'b011,
        OP_WATCH     = 3'b100,
        OP_STANDBY   = 3'b101
    } op_mode_t;

    typedef enum logic [3:0] {
        SEL_NONE       = 4'b0000,
        SEL_P2_MODE    = 4'b0001,
        SEL_P2_DRIVE   = 4'b0010,
        SEL_P2_DATA    = 4'b0011,
        SEL_P2_DIR     = 4'b0100,
        SEL_P1_MODE    = 4'b0101,
        SEL_P1_PULLUP  = 4'b0110,
        SEL_P1_DATA    = 4'b0111,
        SEL_P1_DIR     = 4'b1000
    } reg_sel_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pin_drive_t;

    typedef struct packed {
        logic pwm;
        logic tf_high;
        logic tf_low;
        logic clk_out;
    } alt_out_t;

    typedef struct packed {
        logic ext_int1;
        logic capture_gate;
        logic count_dir;
        logic ext_int4;
    } alt_in_t;

    typedef struct packed {
        logic [7:0] p1_data;
        logic [7:0] p1_dir;
        logic [7:0] p1_puc;
        logic [4:0] p1_mode;
        logic [7:0] p2_data;
        logic [7:0] p2_dir;
        logic [7:0] p2_drive;
        logic [7:0] p2_mode;
        logic [7:0] p1_meta;
        logic [7:0] p1_sync;
        logic [7:0] p2_meta;
        logic [7:0] p2_sync;
        pin_drive_t p1_pins;
        logic [7:0] p1_pu;
        pin_drive_t p2_pins;
        alt_in_t    alt_in;
        logic [7:0] rdata;
    } port_state_t;

endpackage
`default_nettype wire

// ### test/pin_board_model.sv
// Board model that turns the block's pin drives into pin levels
`timescale 1ns/1ps
`default_nettype none

module pin_board_model
    import io_port_pkg::*;
(
    input  wire io_port_pkg::pin_drive_t p1_pin_drive,
    input  wire logic [7:0]             p1_pullup_on,
    input  wire io_port_pkg::pin_drive_t p2_pin_drive,
    input  wire logic [7:0]             ext_p1,
    input  wire logic [7:0]             ext_p2,
    output var  logic [7:0]             p1_pin_in,
    output var  logic [7:0]             p2_pin_in
);
    // Released pins show the pull-up or the board's own level
    always_comb
    begin
        p1_pin_in = (p1_pin_drive.oe & p1_pin_drive.out)
                  | (~p1_pin_drive.oe & (p1_pullup_on | ext_p1));
        p2_pin_in = (p2_pin_drive.oe & p2_pin_drive.out) | (~p2_pin_drive.oe & ext_p2);
    end
endmodule
`default_nettype wire

// ### test/tb.sv
// Self-checking testbench of the I/O port block
`timescale 1ns/1ps
`include "io_port_consts.svh"
`default_nettype none

module tb;
    import io_port_pkg::*;
    logic        sys_clk;
    logic        rst;
    reg_req_t    req;
    logic [7:0]  reg_rdata;
    op_mode_t    op_mode;
    logic [2:0]  tbf;
    alt_out_t    alt_out;
    alt_in_t     alt_in;
    logic [7:0]  p1_in;
    logic [7:0]  p2_in;
    logic [7:0]  pu_on;
    pin_drive_t  p1_drv;
    pin_drive_t  p2_drv;
    logic [7:0]  ext_p1;
    logic [7:0]  ext_p2;
    logic [7:0]  r;
    logic [7:0]  d;
    logic [7:0]  u;
    logic [7:0]  pm;
    logic [7:0]  dm;
    logic [7:0]  e1;
    logic [7:0]  e2;
    logic [7:0]  lvl1;
    logic [4:0]  m;
    logic [2:0]  f;
    logic [15:0] p1e;
    logic [15:0] p2e;
    alt_out_t    a;
    int          err_total;
    int          comparisons;

    io_port_pin_function_ctrl u_io_port_pin_function_ctrl (
        .sys_clk(sys_clk), .rst(rst), .reg_req(req), .reg_rdata(reg_rdata),
        .op_mode(op_mode), .timer_b_mode_field(tbf), .alt_out(alt_out), .alt_in(alt_in),
        .p1_pin_in(p1_in), .p1_pin_drive(p1_drv), .p1_pullup_on(pu_on),
        .p2_pin_in(p2_in), .p2_pin_drive(p2_drv)
    );

    pin_board_model u_pin_board_model (
        .p1_pin_drive(p1_drv), .p1_pullup_on(pu_on), .p2_pin_drive(p2_drv),
        .ext_p1(ext_p1), .ext_p2(ext_p2), .p1_pin_in(p1_in), .p2_pin_in(p2_in)
    );

    always #25 sys_clk = ~sys_clk;

    task automatic summarize;
        if (err_total == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] ad, input logic [7:0] dt);
        @(posedge sys_clk);
        req <= '{addr: ad, wdata: dt, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [15:0] ad, input logic [7:0] exp,
                          input logic [7:0] mask);
        @(posedge sys_clk);
        req <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        req.rd <= 1'b0;
        #1;
        chk(name, {8'h00, exp & mask}, {8'h00, reg_rdata & mask});
    endtask

    task automatic settle;
        repeat (5) @(posedge sys_clk);
        #1;
    endtask

    // Port 1 drive: {out masked by oe, oe}
    function automatic logic [15:0] p1_exp(input logic [7:0] rr, dd, input logic [4:0] mm,
                                           input logic [2:0] ff, input alt_out_t aa);
        logic [7:0] oe;
        logic [7:0] out;
        logic [2:0] ao;
        oe = rr;
        out = dd;
        ao = {aa.tf_high, aa.tf_low, aa.clk_out};
        if (ff == 3'h7)
            oe[5] = 1'b0;
        if (mm[4])
        begin
            oe[4] = 1'b1;
            out[4] = aa.pwm;
        end
        if (mm[3])
            oe[3] = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            if (mm[i])
            begin
                oe[i] = 1'b1;
                out[i] = ao[i];
            end
        end
        return {out & oe, oe};
    endfunction

    // Port 2 drive: open-drain pins drive only a low
    function automatic logic [15:0] p2_exp(input logic [7:0] rr, dd, pp, mm);
        logic [7:0] oe;
        oe = rr & ~{6'h00, pp[1:0]} & ~(mm & dd);
        return {dd & oe & ~mm, oe};
    endfunction

    initial
    begin
        sys_clk = 1'b0;
        rst = 1'b1;
        req = '0;
        op_mode = OP_ACTIVE;
        tbf = 3'h0;
        alt_out = '0;
        ext_p1 = 8'h00;
        ext_p2 = 8'h00;
        err_total = 0;
        comparisons = 0;
        void'($urandom(34));
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 0; i < 24; i++)
        begin
            {r, d, u, pm} = $urandom;
            {dm, e1, e2, m} = 29'($urandom);
            {f, a} = 7'($urandom);
            if (i == 0)
            begin
                f = 3'h7;
                m = 5'h1f;
            end
            if (i == 1)
            begin
                r = 8'hff;
                dm = 8'hff;
                d = 8'h0f;
            end
            @(posedge sys_clk);
            op_mode <= i[0] ? OP_SUBACTIVE : OP_ACTIVE;
            tbf <= f;
            alt_out <= a;
            ext_p1 <= e1;
            ext_p2 <= e2;
            wr(`PORT1_DIRECTION_ADDR, r);
            wr(`PORT1_DATA_ADDR, d);
            wr(`PORT1_PULLUP_CTRL_ADDR, u);
            wr(`PORT1_PIN_MODE_ADDR, {3'b000, m});
            wr(`PORT2_DATA_ADDR, d);
            wr(`PORT2_DIRECTION_ADDR, r);
            wr(`PORT2_PIN_MODE_ADDR, pm);
            wr(`PORT2_DRIVE_MODE_ADDR, dm);
            settle;
            p1e = p1_exp(r, d, m, f, a);
            p2e = p2_exp(r, d, pm, dm);
            lvl1 = p1e[15:8] | (~p1e[7:0] & ((~r & u) | e1));
            chk("p1_drive", p1e, {p1_drv.out & p1_drv.oe, p1_drv.oe});
            chk("p1_pullup", {8'h00, ~r & u}, {8'h00, pu_on});
            chk("p2_drive", p2e, {p2_drv.out & p2_drv.oe, p2_drv.oe});
            chk("alt_in", {12'h000, (f == 3'h7) ? lvl1[5] : 1'b1, m[3] ? lvl1[3] : 1'b1,
                pm[1] ? e2[1] : 1'b1, pm[0] ? e2[0] : 1'b1}, {12'h000, alt_in});
            rd_chk("p2_data", `PORT2_DATA_ADDR, (d & r) | (e2 & ~r), 8'hff);
            rd_chk("p1_data", `PORT1_DATA_ADDR, (d & r) | (lvl1 & ~r), 8'hff);
            rd_chk("p1_direction", `PORT1_DIRECTION_ADDR, r, 8'hff);
            rd_chk("p1_pullup_ctrl", `PORT1_PULLUP_CTRL_ADDR, u, 8'hff);
            rd_chk("p1_pin_mode", `PORT1_PIN_MODE_ADDR, {3'b000, m}, 8'hff);
            rd_chk("p2_pin_mode", `PORT2_PIN_MODE_ADDR, pm | 8'hc0, 8'hff);
            rd_chk("p2_drive_mode", `PORT2_DRIVE_MODE_ADDR, dm, 8'hff);
            rd_chk("p2_direction", `PORT2_DIRECTION_ADDR, 8'hff, 8'hff);
        end
        // Sleep, subsleep and watch modes keep port 1 frozen
        for (int k = 2; k < 5; k++)
        begin
            @(posedge sys_clk);
            op_mode <= op_mode_t'(k);
            wr(`PORT1_DIRECTION_ADDR, ~r);
            settle;
            chk("p1_hold", p1e, {p1_drv.out & p1_drv.oe, p1_drv.oe});
            @(posedge sys_clk);
            op_mode <= OP_ACTIVE;
            wr(`PORT1_DIRECTION_ADDR, r);
        end
        @(posedge sys_clk);
        op_mode <= OP_STANDBY;
        settle;
        chk("p1_standby_oe", 16'h0000, {8'h00, p1_drv.oe});
        chk("p1_standby_pullup", {8'h00, ~r & u}, {8'h00, pu_on});
        @(posedge sys_clk);
        rst <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk("p1_reset", 16'h0000, {p1_drv.oe, pu_on});
        chk("p2_reset", 16'h0000, p2_drv);
        @(posedge sys_clk);
        rst <= 1'b0;
        op_mode <= OP_ACTIVE;
        rd_chk("p2_pin_mode_rst", `PORT2_PIN_MODE_ADDR, 8'hc0, 8'hff);
        rd_chk("p2_drive_rst", `PORT2_DRIVE_MODE_ADDR, 8'h00, 8'hff);
        rd_chk("unmapped", 16'hff00, 8'h00, 8'hff);
        rd_chk("p2_pins_rst", `PORT2_DATA_ADDR, e2, 8'hff);
        wr(`PORT2_DIRECTION_ADDR, 8'hff);
        rd_chk("p2_data_rst", `PORT2_DATA_ADDR, 8'h00, 8'hff);
        summarize();
    end

    initial
    begin
        #1000000;
        err_total++;
        summarize();
    end
endmodule
`default_nettype wire
